/* File: core/spm_device.sv */
// Module end of the serial message link: frame parser, command executor
// and reply/event framer.
// Assumes the user side answers register lookups combinationally on clk.
//
// Operation
// - Every frame begins with start byte 0xfb
// - Type high nibble: 0 command, 1 reply
// - Reply reuses command code, high nibble one
// - Event frames carry high nibble two
// - Events sent unprompted, independent of commands
// - Commands get replies, exit none; transmit reply gives status
// - Multi-byte arguments go least significant first
// - Arguments follow type byte, fixed order, unseparated
// - Entry command: length 7, type 0, key
// - Payload-free replies and exit use length 1
// - Reset command: type 2, length 2, kind
// - Kind 0 gives normal reset
// - Kind 1 resets into serial bootloader
// - Kind 2 resets into air bootloader
// - Reset answered by reply 0x12, length 1
// - Register read: type 3, length 4, offset
// - Read carries bank then size, one register
// - Size mismatch returns error, not contents
// - Length byte counts bytes after it
// - Type bits: 5 event, 4 reply, 3..0 code
// - Malformed register read returns error message
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module spm_device import spm_pkg::*; #(
	parameter int          ARG_DEPTH = 8,
	parameter int          VAL_BYTES = 4,
	// Arbitrary entry key
	parameter logic [47:0] ENTRY_KEY = 48'h6b6579303031
) (
	input  wire logic              clk,
	input  wire logic              reset,
	spm_if.dev                     link,
	output      logic              proto_mode,
	output      logic              reset_req,
	output      logic [1:0]        reset_kind,
	output      logic [7:0]        reg_offset,
	output      logic [7:0]        reg_bank,
	input  wire logic [7:0]        reg_size_in,
	input  wire logic [31:0]       reg_value_in,
	output      logic              tx_req,
	output      logic [23:0]       tx_mac,
	input  wire logic              tx_done,
	input  wire logic [7:0]        tx_status,
	input  wire logic              evt_valid,
	input  wire logic [3:0]        evt_code,
	input  wire logic [2:0]        evt_nbytes,
	input  wire logic [31:0]       evt_data,
	output      logic              evt_ready
);
	localparam int IW  = $clog2(ARG_DEPTH);
	localparam int TXD = ARG_DEPTH + 3;
	localparam int TW  = $clog2(TXD + 1);

	typedef enum logic [2:0] {
		D_HUNT = 3'b000,
		D_LEN  = 3'b001,
		D_BODY = 3'b010,
		D_EXEC = 3'b011,
		D_REG  = 3'b100,
		D_TXW  = 3'b101
	} spm_dstate_e;

	spm_dstate_e pstate;
	logic [7:0]  rx_buf [ARG_DEPTH];
	logic [7:0]  rx_len;
	logic [7:0]  rx_cnt;
	logic [7:0]  tx_buf [TXD];
	logic [TW-1:0] tx_left;
	logic        tx_busy;
	logic        txd_seen;
	logic [7:0]  txd_stat;
	logic        h2d_fire;
	logic        key_ok;
	logic        size_ok;
	logic        rep_go;
	logic [7:0]  rep_type;
	logic [3:0]  rep_n;
	logic [7:0]  rep_arg [ARG_DEPTH];
	logic        exec_end;
	logic        enter_mode;
	logic        leave_mode;
	logic        fire_reset;
	logic        fire_tx;
	logic        to_reg;
	logic        ld_go;
	logic [7:0]  ld_type;
	logic [3:0]  ld_n;
	logic [7:0]  ld_arg [ARG_DEPTH];

	// ========================================
	// Parser
	assign link.h2d_ready = (pstate == D_HUNT) || (pstate == D_LEN) || (pstate == D_BODY);
	assign h2d_fire = link.h2d_valid && link.h2d_ready;
	// Key is a text string, so it is compared first byte first
	assign key_ok = {rx_buf[1], rx_buf[2], rx_buf[3], rx_buf[4], rx_buf[5], rx_buf[6]}
		== ENTRY_KEY;
	assign size_ok = (rx_buf[3] == reg_size_in) && (reg_size_in != 8'h00)
		&& (reg_size_in <= 8'(VAL_BYTES));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pstate <= D_HUNT;
			rx_len <= 8'h00;
			rx_cnt <= 8'h00;
			for (int i = 0; i < ARG_DEPTH; i++) rx_buf[i] <= 8'h00;
		end else begin
			case (pstate)
				D_HUNT: if (h2d_fire && link.h2d_data == SOF_BYTE) pstate <= D_LEN;
				D_LEN: if (h2d_fire) begin
					rx_len <= link.h2d_data;
					rx_cnt <= 8'h00;
					pstate <= (link.h2d_data == 8'h00) ? D_HUNT : D_BODY;
				end
				D_BODY: if (h2d_fire) begin
					// Bytes beyond the buffer are counted but dropped
					if (rx_cnt < 8'(ARG_DEPTH)) rx_buf[IW'(rx_cnt)] <= link.h2d_data;
					rx_cnt <= rx_cnt + 8'h01;
					if (rx_cnt == rx_len - 8'h01) pstate <= D_EXEC;
				end
				D_EXEC: begin
					if (to_reg) pstate <= D_REG;
					else if (fire_tx) pstate <= D_TXW;
					else if (exec_end) pstate <= D_HUNT;
				end
				D_REG, D_TXW: if (exec_end) pstate <= D_HUNT;
				default: pstate <= D_HUNT;
			endcase
		end
	end

	// ========================================
	// Executor
	always_comb begin
		rep_go = 1'b0;
		rep_type = 8'h00;
		rep_n = 4'h0;
		exec_end = 1'b0;
		enter_mode = 1'b0;
		leave_mode = 1'b0;
		fire_reset = 1'b0;
		fire_tx = 1'b0;
		to_reg = 1'b0;
		for (int i = 0; i < ARG_DEPTH; i++) rep_arg[i] = 8'h00;
		case (pstate)
			// Waits for the framer so a reply is never dropped
			D_EXEC: if (!tx_busy) begin
				exec_end = 1'b1;
				if (rx_buf[0][7:4] != DIR_CMD) begin
				end else if (!proto_mode) begin
					if (rx_buf[0][3:0] == CODE_ENTRY && rx_len == LEN_ENTRY && key_ok) begin
						enter_mode = 1'b1;
						rep_go = 1'b1;
						rep_type = spm_mk_type(DIR_REPLY, CODE_ENTRY);
					end
				end else begin
					case (rx_buf[0][3:0])
						CODE_ENTRY: begin
							rep_go = 1'b1;
							rep_type = spm_mk_type(DIR_REPLY, CODE_ENTRY);
						end
						CODE_EXIT: leave_mode = 1'b1;
						CODE_RESET: begin
							rep_go = 1'b1;
							if (rx_len == LEN_RESET && rx_buf[1] <= RESET_OTA) begin
								fire_reset = 1'b1;
								rep_type = spm_mk_type(DIR_REPLY, CODE_RESET);
							end else begin
								rep_type = spm_mk_type(DIR_EVENT, CODE_ERROR);
								rep_n = 4'h1;
								rep_arg[0] = ERR_FORMAT;
							end
						end
						CODE_REG_READ: begin
							if (rx_len == LEN_REG_READ) begin
								to_reg = 1'b1;
								exec_end = 1'b0;
							end else begin
								rep_go = 1'b1;
								rep_type = spm_mk_type(DIR_EVENT, CODE_ERROR);
								rep_n = 4'h1;
								rep_arg[0] = ERR_FORMAT;
							end
						end
						CODE_TRANSMIT: begin
							if (rx_len >= LEN_TX_MIN) begin
								fire_tx = 1'b1;
								exec_end = 1'b0;
							end else begin
								rep_go = 1'b1;
								rep_type = spm_mk_type(DIR_EVENT, CODE_ERROR);
								rep_n = 4'h1;
								rep_arg[0] = ERR_FORMAT;
							end
						end
						default: ;
					endcase
				end
			end
			D_REG: if (!tx_busy) begin
				exec_end = 1'b1;
				rep_go = 1'b1;
				if (size_ok) begin
					rep_type = spm_mk_type(DIR_REPLY, CODE_REG_READ);
					rep_n = 4'h3 + reg_size_in[3:0];
					rep_arg[0] = reg_offset;
					rep_arg[1] = reg_bank;
					rep_arg[2] = reg_size_in;
					for (int i = 0; i < VAL_BYTES; i++) rep_arg[3+i] = reg_value_in[8*i +: 8];
				end else begin
					rep_type = spm_mk_type(DIR_EVENT, CODE_ERROR);
					rep_n = 4'h1;
					rep_arg[0] = ERR_SIZE;
				end
			end
			D_TXW: if (!tx_busy && txd_seen) begin
				exec_end = 1'b1;
				rep_go = 1'b1;
				rep_type = spm_mk_type(DIR_REPLY, CODE_TRANSMIT);
				rep_n = 4'h1;
				rep_arg[0] = txd_stat;
			end
			default: ;
		endcase
		// Replies take the framer first; events fill the gaps
		ld_go = !tx_busy && (rep_go || evt_valid);
		ld_type = rep_go ? rep_type : spm_mk_type(DIR_EVENT, evt_code);
		ld_n = rep_go ? rep_n : ((evt_nbytes > 3'(EVT_MAX_BYTES)) ? 4'(EVT_MAX_BYTES)
			: {1'b0, evt_nbytes});
		for (int i = 0; i < ARG_DEPTH; i++) ld_arg[i] = rep_arg[i];
		if (!rep_go) begin
			for (int i = 0; i < EVT_MAX_BYTES; i++) ld_arg[i] = evt_data[8*i +: 8];
		end
	end

	assign evt_ready = !tx_busy && !rep_go;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) proto_mode <= 1'b0;
		else if (enter_mode) proto_mode <= 1'b1;
		else if (leave_mode) proto_mode <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reset_req <= 1'b0;
			reset_kind <= 2'b00;
			tx_req <= 1'b0;
			tx_mac <= 24'h000000;
			reg_offset <= 8'h00;
			reg_bank <= 8'h00;
		end else begin
			reset_req <= fire_reset;
			// 0 normal, 1 serial bootloader, 2 air bootloader
			if (fire_reset) reset_kind <= rx_buf[1][1:0];
			tx_req <= fire_tx;
			if (fire_tx) tx_mac <= {rx_buf[3], rx_buf[2], rx_buf[1]};
			if (to_reg) begin
				reg_offset <= rx_buf[1];
				reg_bank <= rx_buf[2];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			txd_seen <= 1'b0;
			txd_stat <= 8'h00;
		end else if (fire_tx) begin
			txd_seen <= 1'b0;
		end else if (pstate == D_TXW && tx_done && !txd_seen) begin
			txd_seen <= 1'b1;
			txd_stat <= tx_status;
		end
	end

	// ========================================
	// Framer: shift register, head byte drives the link
	assign link.d2h_data = tx_buf[0];
	assign link.d2h_valid = tx_busy;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_busy <= 1'b0;
			tx_left <= '0;
			for (int i = 0; i < TXD; i++) tx_buf[i] <= 8'h00;
		end else if (ld_go) begin
			tx_buf[0] <= SOF_BYTE;
			tx_buf[1] <= {4'h0, ld_n} + LEN_NOARG;
			tx_buf[2] <= ld_type;
			for (int i = 0; i < ARG_DEPTH; i++) tx_buf[3+i] <= ld_arg[i];
			tx_left <= TW'(ld_n) + TW'(2);
			tx_busy <= 1'b1;
		end else if (tx_busy && link.d2h_ready) begin
			for (int i = 0; i < TXD - 1; i++) tx_buf[i] <= tx_buf[i+1];
			tx_buf[TXD-1] <= 8'h00;
			if (tx_left == '0) tx_busy <= 1'b0;
			else tx_left <= tx_left - TW'(1);
		end
	end
endmodule

/* File: core/spm_pkg.sv */
// Shared constants for the serial message link: framing bytes, type codes,
// lengths, reset kinds and the controller's register map.
// Assumes both ends are compiled against this one package.
package spm_pkg;
	// ========================================
	// Framing
	localparam logic [7:0] SOF_BYTE       = 8'hfb;
	localparam logic [3:0] DIR_CMD        = 4'h0;
	localparam logic [3:0] DIR_REPLY      = 4'h1;
	localparam logic [3:0] DIR_EVENT      = 4'h2;
	localparam int         TYPE_EVENT_BIT = 5;
	localparam int         TYPE_REPLY_BIT = 4;
	// ========================================
	// Message codes (low nibble of the type byte)
	localparam logic [3:0] CODE_ENTRY     = 4'h0;
	localparam logic [3:0] CODE_EXIT      = 4'h1;
	localparam logic [3:0] CODE_RESET     = 4'h2;
	localparam logic [3:0] CODE_REG_READ  = 4'h3;
	localparam logic [3:0] CODE_TRANSMIT  = 4'h5;
	localparam logic [3:0] CODE_ERROR     = 4'h7;
	// ========================================
	// Length bytes
	localparam logic [7:0] LEN_ENTRY      = 8'h07;
	localparam logic [7:0] LEN_NOARG      = 8'h01;
	localparam logic [7:0] LEN_RESET      = 8'h02;
	localparam logic [7:0] LEN_REG_READ   = 8'h04;
	localparam logic [7:0] LEN_TX_MIN     = 8'h04;
	// ========================================
	// Reset kinds and error codes
	localparam logic [7:0] RESET_NORMAL   = 8'h00;
	localparam logic [7:0] RESET_SERIAL   = 8'h01;
	localparam logic [7:0] RESET_OTA      = 8'h02;
	localparam logic [7:0] ERR_FORMAT     = 8'h01;
	localparam logic [7:0] ERR_SIZE       = 8'h02;
	localparam int         EVT_MAX_BYTES  = 4;
	// ========================================
	// Controller register map (APB byte addresses)
	localparam logic [7:0] OFF_CMD        = 8'h00;
	localparam logic [7:0] OFF_ARG0       = 8'h04;
	localparam logic [7:0] OFF_ARG1       = 8'h08;
	localparam logic [7:0] OFF_STATUS     = 8'h0c;
	localparam logic [7:0] OFF_RXHDR      = 8'h10;
	localparam logic [7:0] OFF_RXD0       = 8'h14;
	localparam logic [7:0] OFF_RXD1       = 8'h18;

	function automatic logic [7:0] spm_mk_type(input logic [3:0] dir, input logic [3:0] code);
		return {dir, code};
	endfunction
endpackage

/* File: core/spm_if.sv */
// Byte-stream link between the controller and the module, one byte per
// valid/ready handshake in each direction.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface spm_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       d2h_ready;

	modport dev (input h2d_data, input h2d_valid, output h2d_ready,
		output d2h_data, output d2h_valid, input d2h_ready);
	modport host (output h2d_data, output h2d_valid, input h2d_ready,
		input d2h_data, input d2h_valid, output d2h_ready);
endinterface

/* File: core/spm_host.sv */
// Controller end of the serial message link: software frames commands and
// reads back replies and events through APB registers.
// Assumes APB runs on clk and the module end shares that clock.
`timescale 1ns/1ps
module spm_host import spm_pkg::*; #(
	parameter int ARG_DEPTH = 8
) (
	input  wire logic        clk,
	input  wire logic        reset,
	spm_if.host              link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr
);
	localparam int TXD = ARG_DEPTH + 3;
	localparam int TW  = $clog2(TXD + 1);
	localparam int IW  = $clog2(ARG_DEPTH);

	typedef enum logic [1:0] {
		H_HUNT = 2'b00,
		H_LEN  = 2'b01,
		H_BODY = 2'b10
	} spm_hstate_e;

	spm_hstate_e hstate;
	logic [31:0] arg0;
	logic [31:0] arg1;
	logic [7:0]  tx_buf [TXD];
	logic [TW-1:0] tx_left;
	logic        tx_busy;
	logic [7:0]  rx_buf [ARG_DEPTH];
	logic [7:0]  rx_len;
	logic [7:0]  rx_cnt;
	logic        rx_valid;
	logic        rx_done;
	logic        acc;
	logic        mapped;
	logic        cmd_go;
	logic [3:0]  cmd_n;
	logic [7:0]  arg_b [ARG_DEPTH];

	// ========================================
	// APB slave, zero wait states
	assign acc = psel && penable;
	assign mapped = (paddr == OFF_CMD) || (paddr == OFF_ARG0) || (paddr == OFF_ARG1)
		|| (paddr == OFF_STATUS) || (paddr == OFF_RXHDR) || (paddr == OFF_RXD0)
		|| (paddr == OFF_RXD1);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	// A command written while a frame is going out is dropped, and so is a type
	// byte without the command direction: the host never frames a reply or event
	assign cmd_go = acc && pwrite && paddr == OFF_CMD && !tx_busy
		&& pwdata[7:4] == DIR_CMD;
	assign cmd_n = (pwdata[11:8] > 4'(ARG_DEPTH)) ? 4'(ARG_DEPTH) : pwdata[11:8];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			arg_b[i] = arg0[8*i +: 8];
			arg_b[4+i] = arg1[8*i +: 8];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			arg0 <= 32'h00000000;
			arg1 <= 32'h00000000;
		end else if (acc && pwrite) begin
			if (paddr == OFF_ARG0) arg0 <= pwdata;
			if (paddr == OFF_ARG1) arg1 <= pwdata;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_ARG0: prdata <= arg0;
				OFF_ARG1: prdata <= arg1;
				OFF_STATUS: prdata <= {30'h0, rx_valid, tx_busy};
				OFF_RXHDR: prdata <= {16'h0000, rx_len, rx_buf[0]};
				OFF_RXD0: prdata <= {rx_buf[4], rx_buf[3], rx_buf[2], rx_buf[1]};
				OFF_RXD1: prdata <= {8'h00, rx_buf[7], rx_buf[6], rx_buf[5]};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ========================================
	// Framer
	assign link.h2d_data = tx_buf[0];
	assign link.h2d_valid = tx_busy;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_busy <= 1'b0;
			tx_left <= '0;
			for (int i = 0; i < TXD; i++) tx_buf[i] <= 8'h00;
		end else if (cmd_go) begin
			tx_buf[0] <= SOF_BYTE;
			tx_buf[1] <= {4'h0, cmd_n} + LEN_NOARG;
			tx_buf[2] <= pwdata[7:0];
			for (int i = 0; i < ARG_DEPTH; i++) tx_buf[3+i] <= arg_b[i];
			tx_left <= TW'(cmd_n) + TW'(2);
			tx_busy <= 1'b1;
		end else if (tx_busy && link.h2d_ready) begin
			for (int i = 0; i < TXD - 1; i++) tx_buf[i] <= tx_buf[i+1];
			tx_buf[TXD-1] <= 8'h00;
			if (tx_left == '0) tx_busy <= 1'b0;
			else tx_left <= tx_left - TW'(1);
		end
	end

	// ========================================
	// Receiver: holds one frame until software reads its header
	assign link.d2h_ready = !rx_valid;
	assign rx_done = hstate == H_BODY && link.d2h_valid && !rx_valid
		&& rx_cnt == rx_len - 8'h01;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hstate <= H_HUNT;
			rx_len <= 8'h00;
			rx_cnt <= 8'h00;
			for (int i = 0; i < ARG_DEPTH; i++) rx_buf[i] <= 8'h00;
		end else if (link.d2h_valid && !rx_valid) begin
			case (hstate)
				H_HUNT: if (link.d2h_data == SOF_BYTE) hstate <= H_LEN;
				H_LEN: begin
					rx_len <= link.d2h_data;
					rx_cnt <= 8'h00;
					hstate <= (link.d2h_data == 8'h00) ? H_HUNT : H_BODY;
				end
				H_BODY: begin
					if (rx_cnt < 8'(ARG_DEPTH)) rx_buf[IW'(rx_cnt)] <= link.d2h_data;
					rx_cnt <= rx_cnt + 8'h01;
					if (rx_done) hstate <= H_HUNT;
				end
				default: hstate <= H_HUNT;
			endcase
		end
	end

	// New frame beats a header read in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) rx_valid <= 1'b0;
		else if (rx_done) rx_valid <= 1'b1;
		else if (acc && !pwrite && paddr == OFF_RXHDR) rx_valid <= 1'b0;
	end
endmodule

/* File: dv/spm_properties.sv */
// Link checker: watches the byte stream between both ends of the link.
// Assumes one clock and the interface signals wired in by name.
`timescale 1ns/1ps
module spm_properties import spm_pkg::*; (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic       h2d_ready,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid,
	input wire logic       d2h_ready
);
	// ========================================
	// Frame position: 0 start, 1 length, 2 type, 3 arguments
	logic [1:0] dp;
	logic [1:0] hp;
	logic [7:0] dl;
	logic [7:0] dr;
	logic [7:0] hr;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dp <= 2'd0;
			dl <= 8'h00;
			dr <= 8'h00;
		end else if (d2h_valid && d2h_ready) begin
			if (dp == 2'd1) begin
				dl <= d2h_data;
				dr <= d2h_data;
			end else if (dp != 2'd0) begin
				dr <= dr - 8'h01;
			end
			dp <= (dp == 2'd0) ? 2'd1 : (dp == 2'd1) ? ((d2h_data == 8'h00) ? 2'd0 : 2'd2) :
				((dr == 8'h01) ? 2'd0 : 2'd3);
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hp <= 2'd0;
			hr <= 8'h00;
		end else if (h2d_valid && h2d_ready) begin
			hr <= (hp == 2'd1) ? h2d_data : hr - 8'h01;
			hp <= (hp == 2'd0) ? 2'd1 : (hp == 2'd1) ? ((h2d_data == 8'h00) ? 2'd0 : 2'd2) :
				((hr == 8'h01) ? 2'd0 : 2'd3);
		end
	end
	// ========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_dev_start_byte: assert property (
		d2h_valid && dp == 2'd0 |-> d2h_data == SOF_BYTE) else $error("device frame start wrong");
	a_host_start_byte: assert property (
		h2d_valid && hp == 2'd0 |-> h2d_data == SOF_BYTE) else $error("host frame start wrong");
	a_dev_type_dir: assert property (
		d2h_valid && dp == 2'd2 |-> d2h_data[7:6] == 2'b00 && (d2h_data[5] ^ d2h_data[4]))
		else $error("device type byte direction wrong");
	a_host_cmd_dir: assert property (
		h2d_valid && hp == 2'd2 |-> h2d_data[7:4] == DIR_CMD) else $error("host type not command");
	a_noarg_reply_len: assert property (
		d2h_valid && dp == 2'd2 && (d2h_data == 8'h10 || d2h_data == 8'h12) |-> dl == LEN_NOARG)
		else $error("payload-free reply length wrong");
	a_error_len: assert property (
		d2h_valid && dp == 2'd2 && d2h_data == 8'h27 |-> dl == 8'h02) else $error("error length");
	a_read_reply_len: assert property (
		d2h_valid && dp == 2'd2 && d2h_data == 8'h13 |-> dl >= 8'h05 && dl <= 8'h08)
		else $error("read reply length out of range");
	a_byte_holds: assert property (
		d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data)) else $error("byte dropped");
	a_exec_stall: assert property (
		h2d_valid && h2d_ready && hp[1] && hr == 8'h01 |=> !h2d_ready)
		else $error("frame end not acted on");
endmodule

/* File: dv/serial_protocol_msg_parser_bench.sv */
// Bench: controller end driven over APB, module end's user side driven
// directly. Assumes the default entry key of the module end.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module serial_protocol_msg_parser_bench import spm_pkg::*;;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, perr;
	logic        proto_mode, reset_req, tx_req, tx_done, evt_valid, evt_ready;
	logic [1:0]  reset_kind;
	logic [2:0]  evt_nbytes;
	logic [3:0]  evt_code;
	logic [7:0]  paddr, reg_offset, reg_bank, reg_size_in, tx_status, typ, len;
	logic [23:0] tx_mac;
	logic [31:0] pwdata, prdata, reg_value_in, evt_data, d0, d1;
	int          failures = 0, n_tests = 0, cyc = 0, n_rst = 0, n_tx = 0;
	// ========================================
	// Both ends and the link checker
	spm_if lnk ();
	spm_device i_spm_device (.clk(clk), .reset(reset), .link(lnk), .proto_mode(proto_mode),
		.reset_req(reset_req), .reset_kind(reset_kind), .reg_offset(reg_offset),
		.reg_bank(reg_bank), .reg_size_in(reg_size_in), .reg_value_in(reg_value_in),
		.tx_req(tx_req), .tx_mac(tx_mac), .tx_done(tx_done), .tx_status(tx_status),
		.evt_valid(evt_valid), .evt_code(evt_code), .evt_nbytes(evt_nbytes),
		.evt_data(evt_data), .evt_ready(evt_ready));
	spm_host i_spm_host (.clk(clk), .reset(reset), .link(lnk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	spm_properties i_spm_properties (.clk(clk), .reset(reset), .h2d_data(lnk.h2d_data),
		.h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready), .d2h_data(lnk.d2h_data),
		.d2h_valid(lnk.d2h_valid), .d2h_ready(lnk.d2h_ready));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pulse counters; the ceiling is far above the thousand or so cycles needed
	always @(posedge clk) begin
		cyc++;
		if (reset_req === 1'b1) n_rst++;
		if (tx_req === 1'b1) n_tx++;
		if (cyc == 40000) begin
			failures++;
			end_sim;
		end
	end
	// ========================================
	// Bus and frame tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input logic [7:0] t, input logic [3:0] n, input logic [63:0] args);
		logic [31:0] s;
		apb(1'b1, OFF_ARG0, args[31:0], s);
		apb(1'b1, OFF_ARG1, args[63:32], s);
		apb(1'b1, OFF_CMD, {20'h0, n, t}, s);
		// A command written while busy would be dropped, so wait it out
		do apb(1'b0, OFF_STATUS, 32'h0, s); while (s[0] !== 1'b0);
	endtask
	task automatic get_frame;
		logic [31:0] s;
		int k;
		s = 32'h0;
		for (k = 0; k < 200 && s[1] !== 1'b1; k++) apb(1'b0, OFF_STATUS, 32'h0, s);
		`CHK(s[1], 1'b1)
		apb(1'b0, OFF_RXD0, 32'h0, d0);
		apb(1'b0, OFF_RXD1, 32'h0, d1);
		apb(1'b0, OFF_RXHDR, 32'h0, s);
		typ = s[7:0];
		len = s[15:8];
	endtask
	task automatic quiet;
		logic [31:0] s;
		repeat (40) apb(1'b0, OFF_STATUS, 32'h0, s);
		`CHK(s[1], 1'b0)
	endtask
	task automatic chk_err(input logic [7:0] code);
		get_frame;
		`CHK(typ, 8'h27)
		`CHK(len, 8'h02)
		`CHK(d0[7:0], code)
	endtask
	// ========================================
	// Scenarios
	task automatic t_entry;
		send(8'h02, 4'd1, 64'h0);
		quiet;
		send(8'h00, 4'd6, 64'h0000_3230_3079_656b);
		quiet;
		`CHK(proto_mode, 1'b0)
		send(8'h00, 4'd6, 64'h0000_3130_3079_656b);
		get_frame;
		`CHK(typ, 8'h10)
		`CHK(len, LEN_NOARG)
		`CHK(proto_mode, 1'b1)
		send(8'h13, 4'd0, 64'h0);
		quiet;
	endtask
	task automatic t_reset_kinds;
		int k;
		int n0;
		for (k = 0; k < 3; k++) begin
			n0 = n_rst;
			send(8'h02, 4'd1, 64'(k));
			get_frame;
			`CHK(typ, 8'h12)
			`CHK(len, LEN_NOARG)
			`CHK(n_rst - n0, 1)
			`CHK(reset_kind, 2'(k))
		end
		send(8'h02, 4'd1, 64'h3);
		chk_err(ERR_FORMAT);
	endtask
	task automatic t_reg_read;
		reg_size_in  <= 8'h04;
		reg_value_in <= 32'h44332211;
		send(8'h03, 4'd3, 64'h0004_025a);
		get_frame;
		`CHK(typ, 8'h13)
		`CHK(len, 8'h08)
		`CHK(d0, 32'h1104_025a)
		`CHK(d1[23:0], 24'h443322)
		`CHK({reg_bank, reg_offset}, 16'h025a)
		reg_size_in <= 8'h02;
		send(8'h03, 4'd3, 64'h0004_025a);
		chk_err(ERR_SIZE);
		send(8'h03, 4'd1, 64'h5a);
		chk_err(ERR_FORMAT);
	endtask
	task automatic t_transmit;
		int k;
		int n0;
		n0 = n_tx;
		send(8'h05, 4'd3, 64'h03_0201);
		for (k = 0; k < 100 && n_tx == n0; k++) @(posedge clk);
		`CHK(tx_mac, 24'h030201)
		tx_status <= 8'h01;
		tx_done   <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		get_frame;
		`CHK(typ, 8'h15)
		`CHK(d0[7:0], 8'h01)
	endtask
	task automatic t_events;
		int k;
		for (k = 6; k < 9; k++) begin
			@(posedge clk);
			evt_code   <= 4'(k);
			// Code 7 shares the error layout, so it carries one status byte
			evt_nbytes <= (k == 7) ? 3'd1 : 3'd2;
			evt_data   <= 32'h0000bbaa;
			evt_valid  <= 1'b1;
			do @(posedge clk); while (evt_ready !== 1'b1);
			evt_valid <= 1'b0;
			get_frame;
			`CHK(typ, {4'h2, 4'(k)})
			`CHK(len, (k == 7) ? 8'h02 : 8'h03)
			`CHK(d0[7:0], 8'haa)
			if (k != 7) `CHK(d0[15:8], 8'hbb)
		end
	endtask
	task automatic t_exit;
		logic [31:0] s;
		send(8'h01, 4'd0, 64'h0);
		quiet;
		`CHK(proto_mode, 1'b0)
		send(8'h03, 4'd3, 64'h0004_025a);
		quiet;
		apb(1'b0, 8'h40, 32'h0, s);
		`CHK(perr, 1'b1)
	endtask
	task automatic end_sim;
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_done, tx_status, evt_valid, evt_code, evt_nbytes, evt_data} = '0;
		reg_size_in  = 8'h00;
		reg_value_in = 32'h0;
		reset = 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_entry;
		t_reset_kinds;
		t_reg_read;
		t_transmit;
		t_events;
		t_exit;
		end_sim;
	end
endmodule
